// [verilog/conv_seq_pkg.sv]
/*
 Constants, register indices, field layouts and carrier types of the converter
 sequencer and result block.
 Assumes a 50 MHz system clock and an Avalon-MM word-addressed register port.
*/
package conv_seq_pkg;

	// Register indices; the Avalon word address equals the index
	localparam logic [7:0] IDX_CTRL_ONE = 8'hb4;
	localparam logic [7:0] IDX_CTRL_TWO = 8'hb5;
	localparam logic [7:0] IDX_CTRL_THREE = 8'hb6;
	localparam logic [7:0] IDX_RES_LOW = 8'hba;
	localparam logic [7:0] IDX_RES_HIGH = 8'hbb;
	localparam logic [7:0] IDX_RNG_LOW = 8'hbc;
	localparam logic [7:0] IDX_RNG_HIGH = 8'hbd;

	// Control one field positions
	localparam int CTRL_EOC_BIT = 7;
	localparam int CTRL_ST_BIT = 6;
	localparam int CTRL_START_SOURCE_SELECT_LSB = 4;
	localparam int CTRL_RANDOM_GEN_CONTROL_LSB = 2;
	localparam int CTRL_RSV_LSB = 0;

	// Reset values
	localparam logic [1:0] START_SOURCE_SELECT_RESET = 2'h3;
	localparam logic [1:0] RANDOM_GEN_CONTROL_RESET = 2'h0;
	localparam logic [1:0] RSV_RESET = 2'h3;
	localparam logic [7:0] CTRL_TWO_RESET = 8'h10;
	localparam logic [7:0] CTRL_THREE_RESET = 8'h00;
	localparam logic [11:0] RESULT_RESET = 12'h000;
	localparam logic [15:0] LFSR_SEED_DEFAULT = 16'hffff;

	// Start sources
	localparam logic [1:0] START_SOURCE_SELECT_EXT_PIN = 2'h0;
	localparam logic [1:0] START_SOURCE_SELECT_FREE_RUN = 2'h1;
	localparam logic [1:0] START_SOURCE_SELECT_TIMER = 2'h2;
	localparam logic [1:0] START_SOURCE_SELECT_SW_BIT = 2'h3;

	// Random generator control codes
	localparam logic [1:0] RANDOM_GEN_CONTROL_IDLE = 2'h0;
	localparam logic [1:0] RANDOM_GEN_CONTROL_STEP = 2'h1;
	localparam int LFSR_UNROLL = 13;
	localparam logic [15:0] LFSR_POLY = 16'h8005;

	// Channel code boundaries
	localparam logic [3:0] CH_FIRST_SINGLE = 4'h0;
	localparam logic [3:0] CH_FIRST_DIFF = 4'h8;
	localparam logic [3:0] CH_FIRST_FIXED = 4'hc;

	// Timing: divider in system clock periods, counts in converter clock periods
	localparam int CONV_CLK_DIV = 6;
	localparam logic [9:0] SETTLE_TICKS = 10'h010;
	localparam logic [9:0] DEC_RATE_BASE = 10'h040;

	// Result limits and resolution masks, indexed by decimation select
	localparam logic [11:0] RES_MAX_POS = 12'h7ff;
	localparam logic [11:0] RES_MAX_NEG = 12'h800;
	localparam logic [3:0][11:0] RES_MASK = {12'hfff, 12'hffc, 12'hff8, 12'hfe0};

	// DMA triggers: nine per-channel lines, the top two shared with audio serial
	localparam int DMA_LINES = 9;
	localparam int DMA_SHARED_FIRST = 7;
	localparam logic [3:0] DMA_IDX_FIXED = 4'h8;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SETTLE = 2'b01,
		ST_CONV = 2'b10
	} conv_state_t;

	typedef struct packed {
		logic eoc;
		logic st;
		logic [1:0] start_source_select;
		logic [1:0] random_gen_control;
		logic [1:0] rsv;
	} ctrl_one_t;

	typedef struct packed {
		logic [1:0] sref;
		logic [1:0] decimation_select;
		logic [3:0] ch;
	} conv_cfg_t;

endpackage

// [verilog/conv_seq_top.sv]
/*
 Converter sequencer and result block: Avalon-MM register slave, start source
 selection, sequence and extra conversion control, decimation filter, result
 formatting, done flag, interrupt and DMA trigger pulses, random generator.
 Assumes the modulator bit stream arrives asynchronously and that timer and
 audio serial triggers are single-cycle pulses on sys_clk_in.
*/
// Operation
// - Single-ended results clamp to 0..2047
// - Differential results signed, 2047 to -2048
// - Result left-aligned across high:low bytes
// - Channel field reads last conversion plus one, or the same code for a fixed end
// - Extra completion loads channel field exactly
// - Converter clock is system clock over six
// - Filter runs decimation-rate converter periods
// - Sixteen settling periods before each conversion
// - Interrupt only on extra conversion completion
// - Per-channel DMA trigger pulses on sequence results
// - Top two DMA lines shared with audio
// - All-channel trigger for sequence, none extra
// - Low byte: four LSBs high, zeros low
// - High byte holds result bits eleven:four
// - Done flag sets, clears on high read
// - Start bit starts when sw-select, idle
// - Start source select chooses trigger event
// - Random control 01 steps LFSR, self-clears
// - Decimation codes give rates 64 to 512
// - Channel codes: single, differential, fixed inputs
`timescale 1ns/10ps
module conv_seq_top
	import conv_seq_pkg::*;
#(
	parameter int CLK_DIV = CONV_CLK_DIV,
	parameter logic [15:0] LFSR_SEED = LFSR_SEED_DEFAULT
) (
	input wire logic sys_clk_in,
	input wire logic arst_n_in,
	input wire logic [7:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic mod_bit_in,
	input wire logic ext_trig_in,
	input wire logic timer_cmp_in,
	input wire logic [1:0] i2s_dma_trig_in,
	output logic [DMA_LINES-1:0] dma_trig_out,
	output logic all_chan_dma_out,
	output logic irq_out,
	output logic [3:0] mux_chan_out,
	output logic [1:0] ref_sel_out
);

	if (CLK_DIV < 2 || CLK_DIV > 8) begin : g_bad_div
		$error("CLK_DIV must lie between 2 and 8");
	end

	localparam logic [2:0] DIV_LAST = 3'(CLK_DIV - 1);

	logic rst_meta_ff;
	logic rst_n;
	logic mod_meta_ff;
	logic mod_sync_ff;
	logic ext_meta_ff;
	logic ext_sync_ff;
	logic ext_prev_ff;
	logic wait_ff;
	logic [31:0] rdata_ff;
	logic [2:0] div_ff;
	conv_state_t state_ff;
	logic [9:0] cnt_ff;
	logic signed [10:0] acc_ff;
	conv_cfg_t act_ff;
	logic is_extra_ff;
	conv_cfg_t cfg_two_ff;
	conv_cfg_t cfg_three_ff;
	logic [3:0] sch_read_ff;
	logic extra_pend_ff;
	logic eoc_ff;
	logic st_ff;
	logic [1:0] start_source_select_ff;
	logic [1:0] random_gen_control_ff;
	logic [1:0] rsv_ff;
	logic [11:0] result_ff;
	logic [15:0] lfsr_ff;
	logic [DMA_LINES-1:0] dma_ff;
	logic all_chan_ff;
	logic irq_ff;
	logic [3:0] mux_ff;
	logic [1:0] ref_ff;

	logic bus_acc;
	logic wr_lane0;
	logic wr_one;
	logic wr_two;
	logic wr_three;
	logic rd_high;
	logic [7:0] rd_mux;
	ctrl_one_t ctrl_view;
	logic tick;
	logic ext_rise;
	logic seq_go;
	logic conv_last;
	logic conv_done;
	logic last_ch;
	logic seq_done;
	logic [9:0] rate;
	logic signed [10:0] nxt_acc;
	logic [3:0] first_ch;
	logic [3:0] dma_idx;

	// Reset release through two flops
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rst_meta_ff <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n <= rst_meta_ff;
		end
	end

	// Pin synchronisers; the first stage feeds only the second
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			mod_meta_ff <= 1'b0;
			mod_sync_ff <= 1'b0;
			ext_meta_ff <= 1'b0;
			ext_sync_ff <= 1'b0;
			ext_prev_ff <= 1'b0;
		end else begin
			mod_meta_ff <= mod_bit_in;
			mod_sync_ff <= mod_meta_ff;
			ext_meta_ff <= ext_trig_in;
			ext_sync_ff <= ext_meta_ff;
			ext_prev_ff <= ext_sync_ff;
		end
	end

	assign ext_rise = ext_sync_ff & ~ext_prev_ff;

	// Bus: one wait cycle, then the access takes effect
	assign bus_acc = (avs_read_in | avs_write_in) & ~wait_ff;
	assign wr_lane0 = avs_write_in & avs_byteenable_in[0] & bus_acc;
	assign wr_one = wr_lane0 & (avs_address_in == IDX_CTRL_ONE);
	assign wr_two = wr_lane0 & (avs_address_in == IDX_CTRL_TWO);
	assign wr_three = wr_lane0 & (avs_address_in == IDX_CTRL_THREE);
	assign rd_high = avs_read_in & bus_acc & (avs_address_in == IDX_RES_HIGH);

	assign ctrl_view = '{eoc: eoc_ff, st: st_ff, start_source_select: start_source_select_ff, random_gen_control: random_gen_control_ff, rsv: rsv_ff};

	always_comb begin
		case (avs_address_in)
			IDX_CTRL_ONE: rd_mux = ctrl_view;
			IDX_CTRL_TWO: rd_mux = {cfg_two_ff.sref, cfg_two_ff.decimation_select, sch_read_ff};
			IDX_CTRL_THREE: rd_mux = cfg_three_ff;
			IDX_RES_LOW: rd_mux = {result_ff[3:0], 4'h0};
			IDX_RES_HIGH: rd_mux = result_ff[11:4];
			IDX_RNG_LOW: rd_mux = lfsr_ff[7:0];
			IDX_RNG_HIGH: rd_mux = lfsr_ff[15:8];
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			wait_ff <= 1'b1;
			rdata_ff <= 32'h0000_0000;
		end else begin
			wait_ff <= ~((avs_read_in | avs_write_in) & wait_ff);
			if ((avs_read_in | avs_write_in) & wait_ff) begin
				rdata_ff <= {24'h00_0000, rd_mux};
			end
		end
	end

	// Converter clock enable from the system clock
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			div_ff <= 3'h0;
		end else if (div_ff == DIV_LAST) begin
			div_ff <= 3'h0;
		end else begin
			div_ff <= div_ff + 3'h1;
		end
	end

	assign tick = (div_ff == DIV_LAST);
	assign rate = DEC_RATE_BASE << act_ff.decimation_select;
	assign nxt_acc = mod_sync_ff ? acc_ff + 11'sd1 : acc_ff - 11'sd1;
	assign conv_last = (state_ff == ST_CONV) & tick & (cnt_ff == rate - 10'h001);
	assign conv_done = conv_last;
	assign last_ch = is_extra_ff | (act_ff.ch == cfg_two_ff.ch);
	assign seq_done = conv_done & ~is_extra_ff & last_ch;

	// Sequence begins at the first code of the written end's group; a fixed end starts at itself
	always_comb begin
		if (cfg_two_ff.ch < CH_FIRST_DIFF) begin
			first_ch = CH_FIRST_SINGLE;
		end else if (cfg_two_ff.ch < CH_FIRST_FIXED) begin
			first_ch = CH_FIRST_DIFF;
		end else begin
			first_ch = cfg_two_ff.ch;
		end
	end

	always_comb begin
		case (start_source_select_ff)
			START_SOURCE_SELECT_EXT_PIN: seq_go = ext_rise;
			START_SOURCE_SELECT_FREE_RUN: seq_go = 1'b1;
			START_SOURCE_SELECT_TIMER: seq_go = timer_cmp_in;
			START_SOURCE_SELECT_SW_BIT: seq_go = st_ff;
			default: seq_go = 1'b0;
		endcase
	end

	// Scale the ±rate sum to a 12-bit two's complement value
	function automatic logic [11:0] scale(input logic signed [10:0] sum, input logic [1:0] decimation_select,
			input logic diff);
		logic signed [15:0] wide;
		logic [11:0] res;
		wide = 16'($signed(sum)) <<< (3'h5 - {1'b0, decimation_select});
		if (wide > 16'sd2047) begin
			res = RES_MAX_POS;
		end else if (wide < -16'sd2048) begin
			res = RES_MAX_NEG;
		end else begin
			res = wide[11:0];
		end
		// Single-ended inputs cannot go below ground
		if (!diff && res[11]) begin
			res = 12'h000;
		end
		scale = res & RES_MASK[decimation_select];
	endfunction

	// Sequencer and decimation filter
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= ST_IDLE;
			cnt_ff <= 10'h000;
			acc_ff <= 11'sd0;
			act_ff <= CTRL_TWO_RESET;
			is_extra_ff <= 1'b0;
		end else begin
			case (state_ff)
				ST_IDLE: begin
					cnt_ff <= 10'h000;
					// Extra waits for a running sequence; idle, it goes first
					if (extra_pend_ff) begin
						state_ff <= ST_SETTLE;
						act_ff <= cfg_three_ff;
						is_extra_ff <= 1'b1;
					end else if (seq_go) begin
						state_ff <= ST_SETTLE;
						act_ff <= '{sref: cfg_two_ff.sref, decimation_select: cfg_two_ff.decimation_select, ch: first_ch};
						is_extra_ff <= 1'b0;
					end
				end
				ST_SETTLE: begin
					if (tick) begin
						if (cnt_ff == SETTLE_TICKS - 10'h001) begin
							state_ff <= ST_CONV;
							cnt_ff <= 10'h000;
							acc_ff <= 11'sd0;
						end else begin
							cnt_ff <= cnt_ff + 10'h001;
						end
					end
				end
				ST_CONV: begin
					if (tick) begin
						acc_ff <= nxt_acc;
						cnt_ff <= cnt_ff + 10'h001;
						if (conv_last) begin
							cnt_ff <= 10'h000;
							if (last_ch) begin
								state_ff <= ST_IDLE;
							end else begin
								state_ff <= ST_SETTLE;
								act_ff.ch <= act_ff.ch + 4'h1;
							end
						end
					end
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// Result register
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			result_ff <= RESULT_RESET;
		end else if (conv_done) begin
			result_ff <= scale(nxt_acc, act_ff.decimation_select, act_ff.ch[3:2] == 2'b10);
		end
	end

	// Done flag: a completion in the read cycle wins
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			eoc_ff <= 1'b0;
		end else if (conv_done) begin
			eoc_ff <= 1'b1;
		end else if (rd_high) begin
			eoc_ff <= 1'b0;
		end
	end

	// Software start bit and control one fields
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= 1'b0;
			start_source_select_ff <= START_SOURCE_SELECT_RESET;
			rsv_ff <= RSV_RESET;
		end else begin
			if (wr_one) begin
				start_source_select_ff <= avs_writedata_in[CTRL_START_SOURCE_SELECT_LSB +: 2];
				rsv_ff <= avs_writedata_in[CTRL_RSV_LSB +: 2];
			end
			if (seq_done) begin
				st_ff <= 1'b0;
			end else if (wr_one && avs_writedata_in[CTRL_ST_BIT] &&
					avs_writedata_in[CTRL_START_SOURCE_SELECT_LSB +: 2] == START_SOURCE_SELECT_SW_BIT &&
					state_ff == ST_IDLE && !extra_pend_ff) begin
				st_ff <= 1'b1;
			end
		end
	end

	// Random generator: one step of 13 shifts, then the code clears itself
	function automatic logic [15:0] lfsr_step(input logic [15:0] val);
		logic [15:0] v;
		v = val;
		for (int i = 0; i < LFSR_UNROLL; i++) begin
			v = v[15] ? ({v[14:0], 1'b0} ^ LFSR_POLY) : {v[14:0], 1'b0};
		end
		lfsr_step = v;
	endfunction

	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			random_gen_control_ff <= RANDOM_GEN_CONTROL_RESET;
			lfsr_ff <= LFSR_SEED;
		end else begin
			if (random_gen_control_ff == RANDOM_GEN_CONTROL_STEP) begin
				lfsr_ff <= lfsr_step(lfsr_ff);
			end
			if (wr_one) begin
				random_gen_control_ff <= avs_writedata_in[CTRL_RANDOM_GEN_CONTROL_LSB +: 2];
			end else if (random_gen_control_ff == RANDOM_GEN_CONTROL_STEP) begin
				random_gen_control_ff <= RANDOM_GEN_CONTROL_IDLE;
			end
		end
	end

	// Configuration and channel readback
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			cfg_two_ff <= CTRL_TWO_RESET;
			cfg_three_ff <= CTRL_THREE_RESET;
			sch_read_ff <= CTRL_TWO_RESET[3:0];
			extra_pend_ff <= 1'b0;
		end else begin
			if (wr_two) begin
				cfg_two_ff <= avs_writedata_in[7:0];
			end
			if (wr_three) begin
				cfg_three_ff <= avs_writedata_in[7:0];
			end
			if (wr_three) begin
				extra_pend_ff <= 1'b1;
			end else if (state_ff == ST_IDLE) begin
				extra_pend_ff <= 1'b0;
			end
			if (conv_done && is_extra_ff) begin
				sch_read_ff <= act_ff.ch;
			end else if (conv_done) begin
				sch_read_ff <= (cfg_two_ff.ch < CH_FIRST_FIXED) ? act_ff.ch + 4'h1 : act_ff.ch;
			end else if (wr_two) begin
				sch_read_ff <= avs_writedata_in[3:0];
			end
		end
	end

	always_comb begin
		if (act_ff.ch < CH_FIRST_DIFF) begin
			dma_idx = {1'b0, act_ff.ch[2:0]};
		end else if (act_ff.ch < CH_FIRST_FIXED) begin
			dma_idx = {2'b00, act_ff.ch[1:0]};
		end else begin
			dma_idx = DMA_IDX_FIXED;
		end
	end

	// Per-line DMA pulses
	for (genvar gi = 0; gi < DMA_LINES; gi++) begin : g_dma
		logic shared;
		if (gi >= DMA_SHARED_FIRST) begin : g_shared
			assign shared = i2s_dma_trig_in[gi - DMA_SHARED_FIRST];
		end else begin : g_own
			assign shared = 1'b0;
		end
		always_ff @(posedge sys_clk_in or negedge rst_n) begin
			if (!rst_n) begin
				dma_ff[gi] <= 1'b0;
			end else begin
				dma_ff[gi] <= (conv_done && !is_extra_ff && dma_idx == 4'(gi)) || shared;
			end
		end
	end

	// Event outputs and analog selects
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			all_chan_ff <= 1'b0;
			irq_ff <= 1'b0;
			mux_ff <= 4'h0;
			ref_ff <= 2'h0;
		end else begin
			all_chan_ff <= conv_done & ~is_extra_ff;
			irq_ff <= conv_done & is_extra_ff;
			mux_ff <= act_ff.ch;
			ref_ff <= act_ff.sref;
		end
	end

	assign avs_readdata_out = rdata_ff;
	assign avs_waitrequest_out = wait_ff;
	assign dma_trig_out = dma_ff;
	assign all_chan_dma_out = all_chan_ff;
	assign irq_out = irq_ff;
	assign mux_chan_out = mux_ff;
	assign ref_sel_out = ref_ff;

endmodule

// [tb/conv_seq_sva.sv]
/*
 Checker for the converter sequencer top: bus answer timing, pulse outputs.
 Assumes the top-level port names and one clock domain.
*/
`timescale 1ns/10ps
module conv_seq_sva
	import conv_seq_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic arst_n_in,
	input wire logic [7:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_readdata_out,
	input wire logic avs_waitrequest_out,
	input wire logic [1:0] i2s_dma_trig_in,
	input wire logic [DMA_LINES-1:0] dma_trig_out,
	input wire logic all_chan_dma_out,
	input wire logic irq_out
);
	default clocking @(posedge sys_clk_in);
	endclocking
	default disable iff (!arst_n_in);
	sequence ask_s;
		(avs_read_in || avs_write_in) && avs_waitrequest_out;
	endsequence
	sequence answer_s;
		!avs_waitrequest_out ##1 avs_waitrequest_out;
	endsequence
	bus_answer_a: assert property (ask_s |=> answer_s)
		else $error("bus answer not a single cycle");
	bus_quiet_a: assert property (!avs_read_in && !avs_write_in && avs_waitrequest_out
		|=> avs_waitrequest_out) else $error("answer without request");
	irq_pulse_a: assert property ($rose(irq_out) |=> !irq_out) else $error("irq too long");
	irq_alone_a: assert property (irq_out |-> !all_chan_dma_out && dma_trig_out[6:0] == 7'h0)
		else $error("dma trigger on extra conversion");
	chall_pulse_a: assert property (all_chan_dma_out |=> !all_chan_dma_out)
		else $error("all-channel trigger too long");
	chall_lane_a: assert property (all_chan_dma_out |-> dma_trig_out != '0)
		else $error("all-channel trigger without lane");
	lane_chall_a: assert property (dma_trig_out[6:0] != 7'h0 |-> all_chan_dma_out)
		else $error("lane without all-channel trigger");
	shared_lane_a: assert property (i2s_dma_trig_in == 2'h3 |-> ##[0:1] dma_trig_out[8:7] == 2'h3)
		else $error("shared lanes not passed");
	low_nibble_a: assert property (avs_read_in && avs_address_in == IDX_RES_LOW
		&& !avs_waitrequest_out |-> avs_readdata_out[3:0] == 4'h0) else $error("low nibble set");
endmodule
bind conv_seq_top conv_seq_sva chk_i (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
	.avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
	.avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
	.i2s_dma_trig_in(i2s_dma_trig_in), .dma_trig_out(dma_trig_out),
	.all_chan_dma_out(all_chan_dma_out), .irq_out(irq_out));

// [tb/mod_src.sv]
/*
 Modulator stand-in: bit stream all low, all high or random.
 Assumes the same clock as the block; random draws share the bench seed.
*/
`timescale 1ns/10ps
module mod_src (
	input wire logic clk_in,
	input wire logic [1:0] mode_in,
	output logic bit_out = 1'b0
);
	// Constant streams give exact full-scale codes
	always @(posedge clk_in) begin
		bit_out <= (mode_in == 2'h2) ? 1'($urandom) : mode_in[0];
	end
endmodule

// [tb/conv_seq_top_bench.sv]
/*
 Self-checking bench for the converter sequencer top.
 Assumes conv_seq_sva bound to the top and mod_src as stream source.
*/
`timescale 1ns/10ps
module conv_seq_top_bench;
	import conv_seq_pkg::*;
	localparam int D = 2;
	logic clk = 0, rst_n = 0, rd = 0, wr = 0, ext = 0, tmr = 0, wt, mb, allc, irq;
	logic [7:0] adr = 0, q, lo;
	logic [31:0] wd = 0, rdata;
	logic [1:0] i2s = 0, md = 0;
	logic [8:0] dma;
	logic [11:0] e;
	logic [3:0] mux;
	logic [1:0] rf;
	int mismatches = 0, n_checks = 0;
	conv_seq_top #(.CLK_DIV(D)) DUT (.sys_clk_in(clk), .arst_n_in(rst_n), .avs_address_in(adr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'h1),
		.avs_readdata_out(rdata), .avs_waitrequest_out(wt), .mod_bit_in(mb), .ext_trig_in(ext),
		.timer_cmp_in(tmr), .i2s_dma_trig_in(i2s), .dma_trig_out(dma), .all_chan_dma_out(allc),
		.irq_out(irq), .mux_chan_out(mux), .ref_sel_out(rf));
	mod_src src (.clk_in(clk), .mode_in(md), .bit_out(mb));
	initial forever #10 clk = ~clk;
	task finish_test;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] x);
		n_checks++;
		if (g !== x) begin
			mismatches++;
			$display("BAD %0t got %h expected %h", $time, g, x);
		end
	endtask
	// Held until waitrequest is sampled low; no fixed latency assumed
	task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= {24'h0, d};
		do begin
			@(posedge clk);
			n++;
		end while (wt !== 1'b0 && n < 40);
		q = rdata[7:0];
		rd <= 0;
		wr <= 0;
		if (n >= 40)
			chk(0, 1);
	endtask
	// Loose bounds absorb tick phase, sync delay and bus reads in between
	task conv(input int r, input logic [8:0] lane, input logic x);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (allc !== 1'b1 && irq !== 1'b1 && n < 3000);
		chk(n >= (r + 16) * D - 8 && n <= (r + 16) * D + 3 * D + 8, 1);
		chk(dma, lane);
		chk({allc, irq}, {!x, x});
	endtask
	initial begin
		#1ms;
		mismatches++;
		finish_test;
	end
	initial begin
		void'($urandom(69439));
		repeat (3) @(posedge clk);
		rst_n <= 1;
		repeat (3) @(posedge clk);
		bus(0, IDX_CTRL_ONE, 0);
		chk(q, 8'h33);
		bus(1, IDX_RES_HIGH, 8'h5a);
		bus(0, IDX_RES_HIGH, 0);
		chk(q, 0);
		bus(0, IDX_RES_LOW, 0);
		chk(q, 0);
		bus(0, 8'h00, 0);
		chk(q, 0);
		$display("reset test done");
		md <= 1;
		for (int s = 0; s < 4; s++) begin
			e = 12'h7ff & RES_MASK[s];
			bus(1, IDX_CTRL_TWO, {4'h0 | s[1:0], 4'hc});
			bus(1, IDX_CTRL_ONE, 8'h73);
			conv(64 << s, 9'h100, 0);
			bus(0, IDX_CTRL_ONE, 0);
			chk(q[7:6], 2'h2);
			bus(0, IDX_RES_LOW, 0);
			chk(q, {e[3:0], 4'h0});
			bus(0, IDX_RES_HIGH, 0);
			chk(q, e[11:4]);
			bus(0, IDX_CTRL_ONE, 0);
			chk(q[7], 0);
			bus(0, IDX_CTRL_TWO, 0);
			chk(q[3:0], 4'hc);
		end
		$display("decimation test done");
		md <= 0;
		bus(1, IDX_CTRL_TWO, 8'h09);
		bus(1, IDX_CTRL_ONE, 8'h73);
		bus(0, IDX_CTRL_ONE, 0);
		chk(q[6], 1);
		conv(64, 9'h001, 0);
		conv(64, 9'h002, 0);
		bus(0, IDX_RES_HIGH, 0);
		chk(q, 8'h80);
		bus(0, IDX_CTRL_TWO, 0);
		chk(q[3:0], 4'ha);
		// Extra conversion on its own reference to see the analog selects follow it
		bus(1, IDX_CTRL_THREE, 8'h43);
		conv(64, 9'h000, 1);
		chk(mux, 4'h3);
		chk(rf, 2'h1);
		bus(0, IDX_RES_HIGH, 0);
		chk(q, 0);
		bus(0, IDX_CTRL_TWO, 0);
		chk(q[3:0], 4'h3);
		$display("sequence and extra test done");
		md <= 2;
		bus(1, IDX_CTRL_TWO, 8'h12);
		bus(1, IDX_CTRL_ONE, 8'h73);
		for (int c = 0; c < 3; c++) begin
			conv(128, 9'h001 << c, 0);
			bus(0, IDX_RES_HIGH, 0);
			chk(q[7], 0);
		end
		$display("random input test done");
		md <= 1;
		bus(1, IDX_CTRL_TWO, 8'h0c);
		bus(1, IDX_CTRL_ONE, 8'h43);
		bus(0, IDX_CTRL_ONE, 0);
		chk(q[6], 0);
		@(posedge clk) ext <= 1;
		repeat (2) @(posedge clk);
		ext <= 0;
		conv(64, 9'h100, 0);
		bus(1, IDX_CTRL_ONE, 8'h23);
		@(posedge clk) tmr <= 1;
		@(posedge clk) tmr <= 0;
		conv(64, 9'h100, 0);
		bus(1, IDX_CTRL_ONE, 8'h13);
		conv(64, 9'h100, 0);
		conv(64, 9'h100, 0);
		bus(1, IDX_CTRL_ONE, 8'h33);
		repeat (200) @(posedge clk);
		$display("start source test done");
		bus(1, IDX_CTRL_ONE, 8'h37);
		bus(0, IDX_CTRL_ONE, 0);
		chk(q[3:2], 2'h0);
		bus(0, IDX_RNG_LOW, 0);
		lo = q;
		bus(0, IDX_RNG_HIGH, 0);
		chk({q, lo} != 16'hffff, 1);
		@(posedge clk) i2s <= 2'h3;
		@(posedge clk) i2s <= 2'h0;
		@(posedge clk) chk(dma, 9'h180);
		repeat (3) @(posedge clk);
		$display("random generator and shared lane test done");
		finish_test;
	end
endmodule
